// *** rtl/mic_edge_det.v ***
`timescale 1ns/10ps
// falling-edge detector, one stage per active-low request input
module mic_edge_det #(
	parameter N = 5
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [N-1:0] pin_n,
	output wire [N-1:0] fall
);
	reg [N-1:0] prev_q;
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			// idle level is high, so reset to one avoids a false edge
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					prev_q[i] <= 1'b1;
				end else begin
					prev_q[i] <= pin_n[i];
				end
			end
			assign fall[i] = prev_q[i] & ~pin_n[i];
		end
	endgenerate
endmodule

// *** rtl/mic_map.vh ***
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// ********************************************************
// register indices; byte address is four times the index
// ********************************************************
`define MIC_IDX_TCTL      8'h88
`define MIC_IDX_XFLG      8'h91
`define MIC_IDX_SCTL      8'h98
`define MIC_IDX_ENA       8'ha8
`define MIC_IDX_PRI       8'hb8
`define MIC_IDX_TACC      8'hc7
`define MIC_IDX_T2STAT    8'hc9
`define MIC_IDX_WDCTL     8'hd8
`define MIC_IDX_XENA      8'he8
`define MIC_IDX_XPRI      8'hf8
`define MIC_IDX_STATUS    8'h01

// ********************************************************
// reset values
// ********************************************************
`define MIC_RST_BYTE      8'h00

// ********************************************************
// field positions
// ********************************************************
`define MIC_TCTL_SNS0     0
`define MIC_TCTL_FLG0     1
`define MIC_TCTL_SNS1     2
`define MIC_TCTL_FLG1     3
`define MIC_TCTL_RUN0     4
`define MIC_TCTL_OVF0     5
`define MIC_TCTL_RUN1     6
`define MIC_TCTL_OVF1     7
`define MIC_SCTL_RX       0
`define MIC_SCTL_TX       1
`define MIC_XFLG_EXT2     0
`define MIC_XFLG_EXT3     1
`define MIC_XFLG_NET      3
`define MIC_WDCTL_IRQ     3
`define MIC_ENA_GLOBAL    7
`define MIC_ENA_MASK      8'hbf
`define MIC_PRI_MASK      8'h3f
`define MIC_EXT_MASK      8'h1f
`define MIC_XFLG_MASK     8'h0f
`define MIC_WDCTL_MASK    8'h0f

// ********************************************************
// timed access unlock keys
// ********************************************************
`define MIC_TACC_KEY1     8'haa
`define MIC_TACC_KEY2     8'h55

// ********************************************************
// source numbers in natural order and their vectors
// ********************************************************
`define MIC_SRC_EXT0      4'h0
`define MIC_SRC_TMR0      4'h1
`define MIC_SRC_EXT1      4'h2
`define MIC_SRC_TMR1      4'h3
`define MIC_VEC_EXT0      8'h03
`define MIC_VEC_TMR0      8'h0b
`define MIC_VEC_EXT1      8'h13
`define MIC_VEC_TMR1      8'h1b
`define MIC_VEC_UART      8'h23
`define MIC_VEC_TMR2      8'h2b
`define MIC_VEC_EXT2      8'h43
`define MIC_VEC_EXT3      8'h4b
`define MIC_VEC_NET       8'h5b
`define MIC_VEC_WDOG      8'h63

`endif

// *** rtl/mic_prio.v ***
`timescale 1ns/10ps
// picks the lowest-numbered pending source of the high group,
// else the lowest-numbered pending source of the low group
module mic_prio #(
	parameter N = 10
) (
	input  wire [N-1:0] pend,
	input  wire [N-1:0] hi,
	output reg          valid,
	output reg  [3:0]   idx,
	output reg          is_hi
);
	integer i;
	reg     found_hi;
	reg     found_lo;
	reg [3:0] idx_hi;
	reg [3:0] idx_lo;
	always @* begin
		found_hi = 1'b0;
		found_lo = 1'b0;
		idx_hi   = 4'h0;
		idx_lo   = 4'h0;
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (pend[i] & hi[i]) begin
				found_hi = 1'b1;
				idx_hi   = i[3:0];
			end
			if (pend[i] & ~hi[i]) begin
				found_lo = 1'b1;
				idx_lo   = i[3:0];
			end
		end
		valid = found_hi | found_lo;
		is_hi = found_hi;
		idx   = found_hi ? idx_hi : idx_lo;
	end
endmodule

// *** rtl/mic_top.v ***
// Function
// - two priority levels; priority bit 1 puts a source in the high group
// - every request input is sampled on the rising clock edge
// - ext2, ext3, network requests set flags on falling edge; ext0/1 selectable
// - fixed vectors 03..63 in natural order ext0 first, watchdog last
// - ext0, ext1 (edge mode only), timer0, timer1 flags cleared by hardware on vectoring
// - each source gated by its own enable bit
// - enable bit 7 is the global enable
// - enable bits 5..0: timer2, uart, timer1, ext1, timer0, ext0; bit 6 unused
// - software writes to flags act like hardware, except level-mode ext0/1
// - level-mode ext0/ext1 flag follows its pin
// - sense selects at timer control bits 0 and 2; 1 means falling edge
// - timer control flags at bits 7,5,3,1; run bits at 6 and 4
// - priority bits 5..0 for timer2, uart, timer1, ext1, timer0, ext0
// - extended enable: watchdog 4, network 3, reserved 2, ext3 1, ext2 0
// - extended priority: watchdog 4, network 3, reserved 2, ext3 1, ext2 0
// - extended flags: network 3, reserved 2, ext3 1, ext2 0; upper unused
// - uart tx-done bit 1 and rx-done bit 0 share the uart request
// - watchdog flag at bit 3; software setting it raises a request
// - timed access register unlocks writes to watchdog control
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "mic_map.vh"
module mic_top (
	input  wire        CLOCK,
	input  wire        RESET,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [9:0]  PADDR,
	input  wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        EXT_IRQ0_PIN_N,
	input  wire        EXT_IRQ1_PIN_N,
	input  wire        EXT_IRQ2_PIN_N,
	input  wire        EXT_IRQ3_PIN_N,
	input  wire        NET_ENGINE_REQUEST_N,
	input  wire        TIMER0_OVF_EVT,
	input  wire        TIMER1_OVF_EVT,
	input  wire        TIMER2_EVT,
	input  wire        UART_TX_DONE_EVT,
	input  wire        UART_RX_DONE_EVT,
	input  wire        WATCHDOG_EVT,
	input  wire        IRQ_ACK,
	input  wire        IRQ_RETI,
	output wire        IRQ_REQ,
	output wire [7:0]  IRQ_VECTOR,
	output wire        TIMER0_RUN,
	output wire        TIMER1_RUN,
	output wire [5:0]  SERIAL_MODE,
	output wire [2:0]  WDOG_CTRL
);
	localparam NSRC = 10;

	localparam TACC_IDLE = 2'b00;
	localparam TACC_KEY  = 2'b01;
	localparam TACC_OPEN = 2'b10;

	// ********************************************************
	// registers
	// ********************************************************
	reg  [7:0]      tctl_q;
	reg  [7:0]      tctl_d;
	reg  [7:0]      sctl_q;
	reg  [7:0]      sctl_d;
	reg  [7:0]      xflg_q;
	reg  [7:0]      xflg_d;
	reg  [7:0]      wdctl_q;
	reg  [7:0]      wdctl_d;
	reg             t2flag_q;
	reg             t2flag_d;
	reg  [7:0]      ena_q;
	reg  [7:0]      pri_q;
	reg  [7:0]      xena_q;
	reg  [7:0]      xpri_q;
	reg  [1:0]      tacc_q;
	reg  [1:0]      tacc_d;
	reg  [31:0]     rdata_q;
	reg  [7:0]      rd_byte;
	reg             rd_hit;
	reg             req_q;
	reg  [7:0]      vec_q;
	reg  [3:0]      src_q;
	reg             srchi_q;
	reg             hi_busy_q;
	reg             lo_busy_q;

	wire [7:0]      idx;
	wire            wr;
	wire            setup;
	wire [7:0]      wbyte;
	wire [4:0]      fall;
	wire [NSRC-1:0] pend;
	wire [NSRC-1:0] hi;
	wire            win_valid;
	wire [3:0]      win_idx;
	wire            win_hi;
	wire            grant_ok;
	wire            ack;

	// ********************************************************
	// bus slave: zero wait states, read data captured at setup
	// ********************************************************
	assign idx     = PADDR[9:2];
	assign setup   = PSEL & ~PENABLE;
	assign wr      = PSEL & PENABLE & PWRITE;
	assign wbyte   = PWDATA[7:0];
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~rd_hit;
	assign PRDATA  = rdata_q;

	always @* begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			`MIC_IDX_TCTL:   rd_byte = tctl_q;
			`MIC_IDX_XFLG:   rd_byte = xflg_q;
			`MIC_IDX_SCTL:   rd_byte = sctl_q;
			`MIC_IDX_ENA:    rd_byte = ena_q;
			`MIC_IDX_PRI:    rd_byte = pri_q;
			`MIC_IDX_TACC:   rd_byte = 8'h00;
			`MIC_IDX_T2STAT: rd_byte = {7'h00, t2flag_q};
			`MIC_IDX_WDCTL:  rd_byte = wdctl_q;
			`MIC_IDX_XENA:   rd_byte = xena_q;
			`MIC_IDX_XPRI:   rd_byte = xpri_q;
			`MIC_IDX_STATUS: rd_byte = {lo_busy_q, hi_busy_q, srchi_q, req_q, src_q};
			default:         rd_hit  = 1'b0;
		endcase
	end

	always @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			rdata_q <= 32'h00000000;
		end else if (setup & ~PWRITE) begin
			rdata_q <= {24'h000000, rd_byte};
		end
	end

	// ********************************************************
	// request sampling
	// ********************************************************
	mic_edge_det #(
		.N (5)
	) u_edge (
		.clk   (CLOCK),
		.rst   (RESET),
		.pin_n ({NET_ENGINE_REQUEST_N, EXT_IRQ3_PIN_N, EXT_IRQ2_PIN_N,
			EXT_IRQ1_PIN_N, EXT_IRQ0_PIN_N}),
		.fall  (fall)
	);

	assign ack = IRQ_ACK & req_q;

	// ********************************************************
	// timer control: flags, run bits, sense selects
	// ********************************************************
	always @* begin
		tctl_d = tctl_q;
		if (ack & (src_q == `MIC_SRC_EXT0)) begin
			tctl_d[`MIC_TCTL_FLG0] = 1'b0;
		end
		if (ack & (src_q == `MIC_SRC_TMR0)) begin
			tctl_d[`MIC_TCTL_OVF0] = 1'b0;
		end
		if (ack & (src_q == `MIC_SRC_EXT1)) begin
			tctl_d[`MIC_TCTL_FLG1] = 1'b0;
		end
		if (ack & (src_q == `MIC_SRC_TMR1)) begin
			tctl_d[`MIC_TCTL_OVF1] = 1'b0;
		end
		if (wr & (idx == `MIC_IDX_TCTL)) begin
			tctl_d = wbyte;
		end
		// hardware set wins over any clear in the same cycle
		if (TIMER0_OVF_EVT) begin
			tctl_d[`MIC_TCTL_OVF0] = 1'b1;
		end
		if (TIMER1_OVF_EVT) begin
			tctl_d[`MIC_TCTL_OVF1] = 1'b1;
		end
		if (tctl_d[`MIC_TCTL_SNS0] & fall[0]) begin
			tctl_d[`MIC_TCTL_FLG0] = 1'b1;
		end
		if (tctl_d[`MIC_TCTL_SNS1] & fall[1]) begin
			tctl_d[`MIC_TCTL_FLG1] = 1'b1;
		end
		// level mode: flag tracks the pin, writes and vectoring ignored
		if (~tctl_d[`MIC_TCTL_SNS0]) begin
			tctl_d[`MIC_TCTL_FLG0] = ~EXT_IRQ0_PIN_N;
		end
		if (~tctl_d[`MIC_TCTL_SNS1]) begin
			tctl_d[`MIC_TCTL_FLG1] = ~EXT_IRQ1_PIN_N;
		end
	end

	// ********************************************************
	// software-cleared flags
	// ********************************************************
	always @* begin
		sctl_d = sctl_q;
		if (wr & (idx == `MIC_IDX_SCTL)) begin
			sctl_d = wbyte;
		end
		if (UART_TX_DONE_EVT) begin
			sctl_d[`MIC_SCTL_TX] = 1'b1;
		end
		if (UART_RX_DONE_EVT) begin
			sctl_d[`MIC_SCTL_RX] = 1'b1;
		end
	end

	always @* begin
		xflg_d = xflg_q;
		if (wr & (idx == `MIC_IDX_XFLG)) begin
			xflg_d = wbyte & `MIC_XFLG_MASK;
		end
		if (fall[2]) begin
			xflg_d[`MIC_XFLG_EXT2] = 1'b1;
		end
		if (fall[3]) begin
			xflg_d[`MIC_XFLG_EXT3] = 1'b1;
		end
		if (fall[4]) begin
			xflg_d[`MIC_XFLG_NET] = 1'b1;
		end
	end

	always @* begin
		t2flag_d = t2flag_q;
		if (wr & (idx == `MIC_IDX_T2STAT)) begin
			t2flag_d = wbyte[0];
		end
		if (TIMER2_EVT) begin
			t2flag_d = 1'b1;
		end
	end

	// ********************************************************
	// timed access: key1 then key2 opens one watchdog write
	// ********************************************************
	always @* begin
		tacc_d = tacc_q;
		if (wr) begin
			case (tacc_q)
				TACC_IDLE: begin
					if ((idx == `MIC_IDX_TACC) & (wbyte == `MIC_TACC_KEY1)) begin
						tacc_d = TACC_KEY;
					end
				end
				TACC_KEY: begin
					if ((idx == `MIC_IDX_TACC) & (wbyte == `MIC_TACC_KEY2)) begin
						tacc_d = TACC_OPEN;
					end else if ((idx == `MIC_IDX_TACC) & (wbyte == `MIC_TACC_KEY1)) begin
						tacc_d = TACC_KEY;
					end else begin
						tacc_d = TACC_IDLE;
					end
				end
				TACC_OPEN: tacc_d = TACC_IDLE;
				default:   tacc_d = TACC_IDLE;
			endcase
		end
	end

	always @* begin
		wdctl_d = wdctl_q;
		// unlocked write only; a locked write is dropped silently
		if (wr & (idx == `MIC_IDX_WDCTL) & (tacc_q == TACC_OPEN)) begin
			wdctl_d = wbyte & `MIC_WDCTL_MASK;
		end
		if (WATCHDOG_EVT) begin
			wdctl_d[`MIC_WDCTL_IRQ] = 1'b1;
		end
	end

	always @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			tctl_q   <= `MIC_RST_BYTE;
			sctl_q   <= `MIC_RST_BYTE;
			xflg_q   <= `MIC_RST_BYTE;
			wdctl_q  <= `MIC_RST_BYTE;
			t2flag_q <= 1'b0;
			tacc_q   <= TACC_IDLE;
			ena_q    <= `MIC_RST_BYTE;
			pri_q    <= `MIC_RST_BYTE;
			xena_q   <= `MIC_RST_BYTE;
			xpri_q   <= `MIC_RST_BYTE;
		end else begin
			tctl_q   <= tctl_d;
			sctl_q   <= sctl_d;
			xflg_q   <= xflg_d;
			wdctl_q  <= wdctl_d;
			t2flag_q <= t2flag_d;
			tacc_q   <= tacc_d;
			if (wr & (idx == `MIC_IDX_ENA)) begin
				ena_q <= wbyte & `MIC_ENA_MASK;
			end
			if (wr & (idx == `MIC_IDX_PRI)) begin
				pri_q <= wbyte & `MIC_PRI_MASK;
			end
			if (wr & (idx == `MIC_IDX_XENA)) begin
				xena_q <= wbyte & `MIC_EXT_MASK;
			end
			if (wr & (idx == `MIC_IDX_XPRI)) begin
				xpri_q <= wbyte & `MIC_EXT_MASK;
			end
		end
	end

	// ********************************************************
	// pending sources in natural order
	// ********************************************************
	// reserved bit 2 of the extended registers is stored but never raises a request
	assign pend = {NSRC{ena_q[`MIC_ENA_GLOBAL]}} & {
		wdctl_q[`MIC_WDCTL_IRQ] & xena_q[4],
		xflg_q[`MIC_XFLG_NET] & xena_q[3],
		xflg_q[`MIC_XFLG_EXT3] & xena_q[1],
		xflg_q[`MIC_XFLG_EXT2] & xena_q[0],
		t2flag_q & ena_q[5],
		(sctl_q[`MIC_SCTL_TX] | sctl_q[`MIC_SCTL_RX]) & ena_q[4],
		tctl_q[`MIC_TCTL_OVF1] & ena_q[3],
		tctl_q[`MIC_TCTL_FLG1] & ena_q[2],
		tctl_q[`MIC_TCTL_OVF0] & ena_q[1],
		tctl_q[`MIC_TCTL_FLG0] & ena_q[0]};

	assign hi = {xpri_q[4], xpri_q[3], xpri_q[1], xpri_q[0], pri_q[5:0]};

	mic_prio #(
		.N (NSRC)
	) u_prio (
		.pend  (pend),
		.hi    (hi),
		.valid (win_valid),
		.idx   (win_idx),
		.is_hi (win_hi)
	);

	// high may interrupt low service; nothing interrupts high service
	assign grant_ok = win_valid & (win_hi ? ~hi_busy_q : ~(hi_busy_q | lo_busy_q));

	function [7:0] vec_of;
		input [3:0] s;
		begin
			case (s)
				4'h0:    vec_of = `MIC_VEC_EXT0;
				4'h1:    vec_of = `MIC_VEC_TMR0;
				4'h2:    vec_of = `MIC_VEC_EXT1;
				4'h3:    vec_of = `MIC_VEC_TMR1;
				4'h4:    vec_of = `MIC_VEC_UART;
				4'h5:    vec_of = `MIC_VEC_TMR2;
				4'h6:    vec_of = `MIC_VEC_EXT2;
				4'h7:    vec_of = `MIC_VEC_EXT3;
				4'h8:    vec_of = `MIC_VEC_NET;
				default: vec_of = `MIC_VEC_WDOG;
			endcase
		end
	endfunction

	// ********************************************************
	// request to the core and service nesting
	// ********************************************************
	// request drops for one cycle after each acknowledge so the
	// cleared flag and new service level are seen before the next pick
	always @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			req_q     <= 1'b0;
			vec_q     <= 8'h00;
			src_q     <= 4'h0;
			srchi_q   <= 1'b0;
			hi_busy_q <= 1'b0;
			lo_busy_q <= 1'b0;
		end else begin
			req_q <= grant_ok & ~ack;
			if (grant_ok & ~ack) begin
				vec_q   <= vec_of(win_idx);
				src_q   <= win_idx;
				srchi_q <= win_hi;
			end
			if (ack & srchi_q) begin
				hi_busy_q <= 1'b1;
			end else if (IRQ_RETI & hi_busy_q) begin
				hi_busy_q <= 1'b0;
			end
			if (ack & ~srchi_q) begin
				lo_busy_q <= 1'b1;
			end else if (IRQ_RETI & ~hi_busy_q) begin
				lo_busy_q <= 1'b0;
			end
		end
	end

	assign IRQ_REQ     = req_q;
	assign IRQ_VECTOR  = vec_q;
	assign TIMER0_RUN  = tctl_q[`MIC_TCTL_RUN0];
	assign TIMER1_RUN  = tctl_q[`MIC_TCTL_RUN1];
	assign SERIAL_MODE = sctl_q[7:2];
	assign WDOG_CTRL   = wdctl_q[2:0];
endmodule

// *** verif/mic_core_model.sv ***
`timescale 1ns/10ps
// ****
// processor core: branches after ack_dly cycles, returns HOLD cycles later
// ****
module mic_core_model (
	input wire         clk,
	input wire         rst,
	input wire         irq_req,
	input wire [7:0]   irq_vector,
	input wire [3:0]   ack_dly,
	output logic       irq_ack = 1'b0,
	output logic       irq_reti = 1'b0,
	output logic [7:0] n_ack = 8'h00,
	output logic [7:0] last_vec = 8'h00
);
	localparam logic [7:0] HOLD = 8'h28;
	logic [3:0] lat_q;
	logic [3:0] dep_q;
	logic [7:0] tmr_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'b0;
			irq_reti <= 1'b0;
			n_ack <= 8'h00;
			last_vec <= 8'h00;
			lat_q <= 4'h0;
			dep_q <= 4'h0;
			tmr_q <= 8'h00;
		end else begin
			irq_ack <= 1'b0;
			irq_reti <= 1'b0;
			lat_q <= 4'h0;
			if (irq_req && !irq_ack) begin
				lat_q <= lat_q + 4'h1;
				// nesting is allowed: a preempting branch may arrive mid-routine
				if (lat_q >= ack_dly) begin
					irq_ack <= 1'b1;
					last_vec <= irq_vector;
					n_ack <= n_ack + 8'h01;
					dep_q <= dep_q + 4'h1;
					tmr_q <= HOLD;
				end
			end else if (dep_q != 4'h0) begin
				if (tmr_q == 8'h00) begin
					irq_reti <= 1'b1;
					dep_q <= dep_q - 4'h1;
					tmr_q <= HOLD;
				end else
					tmr_q <= tmr_q - 8'h01;
			end
		end
	end
endmodule

// *** verif/mic_props_properties.sv ***
`timescale 1ns/10ps
// ****
// port checker
// ****
module mic_props (
	input wire        CLOCK,
	input wire        RESET,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [9:0]  PADDR,
	input wire [31:0] PWDATA,
	input wire        TIMER0_OVF_EVT,
	input wire        IRQ_ACK,
	input wire        IRQ_RETI,
	input wire        IRQ_REQ,
	input wire [7:0]  IRQ_VECTOR,
	input wire        TIMER0_RUN,
	input wire        TIMER1_RUN,
	input wire [5:0]  SERIAL_MODE,
	input wire [2:0]  WDOG_CTRL
);
	// shadows of what software wrote; flags themselves are not modelled
	logic [7:0] ena_q;
	logic [7:0] xena_q;
	logic [1:0] tacc_q;
	logic [3:0] dep_q;
	wire        wr  = PSEL && PENABLE && PWRITE;
	wire [7:0]  idx = PADDR[9:2];
	wire [7:0]  wd  = PWDATA[7:0];
	wire        any_en = ena_q[7] &&
		((ena_q & 8'h3f) != 8'h00 || (xena_q & 8'h1b) != 8'h00);
	wire        wd_open = wr && idx == 8'hd8 && tacc_q == 2'd2;
	always @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			ena_q <= 8'h00;
			xena_q <= 8'h00;
			tacc_q <= 2'd0;
			dep_q <= 4'd0;
		end else begin
			if (wr && idx == 8'ha8)
				ena_q <= wd & 8'hbf;
			if (wr && idx == 8'he8)
				xena_q <= wd & 8'h1f;
			// any write after the unlock closes it, a first key included
			if (wr)
				tacc_q <= (tacc_q != 2'd2 && idx == 8'hc7 && wd == 8'haa) ? 2'd1 :
					(tacc_q == 2'd1 && idx == 8'hc7 && wd == 8'h55) ? 2'd2 : 2'd0;
			dep_q <= dep_q + {3'd0, IRQ_ACK && IRQ_REQ} - {3'd0, IRQ_RETI};
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	sequence s_t0_arm;
		TIMER0_OVF_EVT && ena_q == 8'h82 && xena_q == 8'h00 && dep_q == 4'd0 &&
			!IRQ_REQ ##1 !IRQ_ACK;
	endsequence
	sequence s_t0_taken;
		IRQ_REQ && IRQ_VECTOR == 8'h0b;
	endsequence
	chk_t0_walk: assert property (s_t0_arm |=> s_t0_taken)
		else $error("timer0 request late or wrong");
	chk_ack_drops: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ)
		else $error("request held after branch");
	chk_global_off: assert property ($fell(ena_q[7]) |=> !IRQ_REQ [*2])
		else $error("request with global enable off");
	chk_needs_enable: assert property (IRQ_REQ |-> $past(any_en))
		else $error("request with no source enabled");
	chk_vector_set: assert property (IRQ_REQ |-> IRQ_VECTOR inside {8'h03, 8'h0b,
		8'h13, 8'h1b, 8'h23, 8'h2b, 8'h43, 8'h4b, 8'h5b, 8'h63})
		else $error("illegal vector");
	chk_wdog_locked: assert property ($changed(WDOG_CTRL) |-> $past(wd_open))
		else $error("watchdog control changed while locked");
	chk_run_bits: assert property (wr && idx == 8'h88 |=>
		TIMER0_RUN == $past(wd[4]) && TIMER1_RUN == $past(wd[6]))
		else $error("run bits wrong");
	chk_serial_mode: assert property (wr && idx == 8'h98 |=> SERIAL_MODE == $past(wd[7:2]))
		else $error("serial mode bits wrong");
endmodule
bind mic_top mic_props i_mic_props (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.TIMER0_OVF_EVT(TIMER0_OVF_EVT), .IRQ_ACK(IRQ_ACK), .IRQ_RETI(IRQ_RETI),
	.IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .TIMER0_RUN(TIMER0_RUN),
	.TIMER1_RUN(TIMER1_RUN), .SERIAL_MODE(SERIAL_MODE), .WDOG_CTRL(WDOG_CTRL));

// *** verif/testbench.sv ***
`timescale 1ns/10ps
// ****
// register and interrupt sequences
// ****
module testbench;
	logic        CLOCK = 1'b0;
	logic        RESET = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [9:0]  ev = 10'h000;
	logic        lo0 = 1'b0;
	logic [3:0]  dly = 4'h0;
	logic [31:0] rq;
	logic        re;
	wire [31:0]  PRDATA;
	wire         PREADY, PSLVERR, IRQ_ACK, IRQ_RETI, IRQ_REQ, TIMER0_RUN, TIMER1_RUN;
	wire [7:0]   IRQ_VECTOR, n_ack, last_vec;
	wire [5:0]   SERIAL_MODE;
	wire [2:0]   WDOG_CTRL;
	integer      err_count = 0;
	integer      n_checks = 0;
	integer      i, na;
	logic [7:0]  vt[10] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h43, 8'h4b, 8'h5b, 8'h63};
	logic [7:0]  ri[10] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h98, 8'hc9, 8'h91, 8'h91, 8'h91, 8'hd8};
	logic [7:0]  ra[10] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h03, 8'h01, 8'h01, 8'h02, 8'h08, 8'h08};
	logic [7:0]  mi[5] = '{8'ha8, 8'hb8, 8'he8, 8'hf8, 8'h91};
	logic [7:0]  mv[5] = '{8'hbf, 8'h3f, 8'h1f, 8'h1f, 8'h0f};
	initial forever #25 CLOCK = ~CLOCK;
	mic_top i_mic_top (.CLOCK(CLOCK), .RESET(RESET), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EXT_IRQ0_PIN_N(!(ev[0] || lo0)), .EXT_IRQ1_PIN_N(!ev[2]),
		.EXT_IRQ2_PIN_N(!ev[6]), .EXT_IRQ3_PIN_N(!ev[7]), .NET_ENGINE_REQUEST_N(!ev[8]),
		.TIMER0_OVF_EVT(ev[1]), .TIMER1_OVF_EVT(ev[3]), .TIMER2_EVT(ev[5]),
		.UART_TX_DONE_EVT(ev[4]), .UART_RX_DONE_EVT(ev[4]), .WATCHDOG_EVT(ev[9]),
		.IRQ_ACK(IRQ_ACK), .IRQ_RETI(IRQ_RETI), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
		.TIMER0_RUN(TIMER0_RUN), .TIMER1_RUN(TIMER1_RUN), .SERIAL_MODE(SERIAL_MODE),
		.WDOG_CTRL(WDOG_CTRL));
	mic_core_model i_mic_core_model (.clk(CLOCK), .rst(RESET), .irq_req(IRQ_REQ),
		.irq_vector(IRQ_VECTOR), .ack_dly(dly), .irq_ack(IRQ_ACK), .irq_reti(IRQ_RETI),
		.n_ack(n_ack), .last_vec(last_vec));
	task tally_and_finish;
		begin
			if (err_count == 0 && n_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("FAIL %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		integer k;
		begin
			@(posedge CLOCK);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= {a, 2'b00};
			pwdata <= {24'h000000, d};
			@(posedge CLOCK);
			penable <= 1'b1;
			k = 0;
			@(posedge CLOCK);
			while (PREADY !== 1'b1) begin
				k = k + 1;
				if (k > 20) begin
					err_count = err_count + 1;
					tally_and_finish;
				end
				@(posedge CLOCK);
			end
			rq = PRDATA;
			re = PSLVERR;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		begin
			apb(a, 1'b0, 8'h00);
			chk(rq, {24'h000000, e});
		end
	endtask
	// watchdog control only accepts a write right after the two-key unlock
	task wdwr(input logic [7:0] d);
		begin
			wr(8'hc7, 8'haa);
			wr(8'hc7, 8'h55);
			wr(8'hd8, d);
		end
	endtask
	task pulse(input integer s);
		begin
			@(posedge CLOCK);
			ev <= 10'd1 << s;
			@(posedge CLOCK);
			ev <= 10'h000;
		end
	endtask
	task wait_ack(input integer n);
		integer k;
		begin
			k = 0;
			while (n_ack !== n[7:0]) begin
				k = k + 1;
				if (k > 400) begin
					err_count = err_count + 1;
					tally_and_finish;
				end
				@(posedge CLOCK);
			end
		end
	endtask
	initial begin
		repeat (3) @(posedge CLOCK);
		RESET <= 1'b0;
		for (i = 0; i < 10; i = i + 1)
			rd(ri[i], 8'h00);
		rd(8'hc7, 8'h00);
		for (i = 0; i < 5; i = i + 1) begin
			rd(mi[i], 8'h00);
			wr(mi[i], 8'hff);
			rd(mi[i], mv[i]);
			wr(mi[i], 8'h00);
		end
		rd(8'h02, 8'h00);
		chk({31'd0, re}, 32'd1);
		lo0 <= 1'b1;
		rd(8'h88, 8'h02);
		wr(8'h88, 8'h00);
		rd(8'h88, 8'h02);
		lo0 <= 1'b0;
		rd(8'h88, 8'h00);
		wr(8'h88, 8'h55);
		wr(8'h98, 8'hfc);
		@(negedge CLOCK);
		chk({TIMER1_RUN, TIMER0_RUN, SERIAL_MODE}, 32'hff);
		wr(8'h98, 8'h00);
		wr(8'h88, 8'h05);
		wr(8'hd8, 8'h03);
		rd(8'hd8, 8'h00);
		wdwr(8'h03);
		rd(8'hd8, 8'h03);
		chk(WDOG_CTRL, 32'd3);
		wdwr(8'h00);
		dly <= 4'h3;
		wr(8'ha8, 8'h02);
		pulse(1);
		repeat (10) @(posedge CLOCK);
		chk(n_ack, 32'd0);
		wr(8'ha8, 8'h82);
		wait_ack(1);
		chk(last_vec, 32'h0b);
		repeat (50) @(posedge CLOCK);
		pulse(1);
		wait_ack(2);
		chk(last_vec, 32'h0b);
		na = 2;
		dly <= 4'h0;
		wr(8'he8, 8'h1b);
		wr(8'ha8, 8'hbf);
		for (i = 0; i < 10; i = i + 1) begin
			pulse(i);
			na = na + 1;
			wait_ack(na);
			chk(last_vec, vt[i]);
			rd(ri[i], ra[i]);
			if (ri[i] == 8'hd8)
				wdwr(8'h00);
			else
				wr(ri[i], (ri[i] == 8'h88) ? 8'h05 : 8'h00);
		end
		dly <= 4'h5;
		wr(8'he8, 8'h03);
		wr(8'ha8, 8'h80);
		wr(8'h91, 8'h03);
		wait_ack(na + 1);
		chk(last_vec, 32'h43);
		wr(8'h91, 8'h02);
		repeat (8) @(posedge CLOCK);
		chk(n_ack, na + 1);
		wr(8'hf8, 8'h02);
		wait_ack(na + 2);
		chk(last_vec, 32'h4b);
		wr(8'h91, 8'h00);
		tally_and_finish;
	end
endmodule
